// ==== src/odp_pkg.sv ====
package odp_pkg;
    // ------------------------------------------------------------
    // register offsets, page one
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PAGE_SELECT  = 8'h00;
    localparam logic [7:0] OFS_RSVD_FIRST   = 8'h01;
    localparam logic [7:0] OFS_RSVD_LAST    = 8'h1D;
    localparam logic [7:0] OFS_ERR_CTRL     = 8'h1E;
    localparam logic [7:0] OFS_HP_CTRL      = 8'h1F;
    localparam logic [7:0] OFS_SPK_CTRL     = 8'h20;
    localparam logic [7:0] PAGE_ONE         = 8'h01;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PAGE_SELECT  = 8'h00;
    localparam logic [7:0] RST_ERR_CTRL     = 8'h00;
    localparam logic [7:0] RST_HP_CTRL      = 8'h04;
    localparam logic [7:0] RST_SPK_CTRL     = 8'h06;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int ERR_SPK_KEEP_BIT = 1;
    localparam int ERR_HP_KEEP_BIT  = 0;
    localparam int HP_POWER_BIT     = 7;
    localparam int HP_CM_MSB        = 4;
    localparam int HP_CM_LSB        = 3;
    localparam int HP_ACTION_BIT    = 1;
    localparam int HP_STATUS_BIT    = 0;
    localparam int SPK_POWER_BIT    = 7;
    localparam int SPK_STATUS_BIT   = 0;

    // ------------------------------------------------------------
    // common-mode levels in millivolts
    // ------------------------------------------------------------
    localparam logic [11:0] CM_MV_CODE0 = 12'h0546; // 1350
    localparam logic [11:0] CM_MV_CODE1 = 12'h05DC; // 1500
    localparam logic [11:0] CM_MV_CODE2 = 12'h0672; // 1650
    localparam logic [11:0] CM_MV_CODE3 = 12'h0708; // 1800
endpackage : odp_pkg

// ==== src/odp_regs.sv ====
`timescale 1ns/1ps
module odp_regs (
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        HP_SHORT_IN,
    input  wire logic        SPK_SHORT_IN,
    output logic      [7:0]  REG_RDATA,
    output logic      [7:0]  PAGE_SEL,
    output logic             HP_DRIVER_EN,
    output logic             HP_CURRENT_LIMIT,
    output logic      [1:0]  HP_CM_SEL,
    output logic      [11:0] HP_CM_MV,
    output logic             SPK_DRIVER_EN
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [1:0] hp_sync_reg;
    logic [1:0] spk_sync_reg;
    logic       hp_short;
    logic       spk_short;

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hp_sync_reg  <= 2'h0;
            spk_sync_reg <= 2'h0;
        end else begin
            hp_sync_reg  <= {hp_sync_reg[0], HP_SHORT_IN};
            spk_sync_reg <= {spk_sync_reg[0], SPK_SHORT_IN};
        end
    end

    assign hp_short  = hp_sync_reg[1];
    assign spk_short = spk_sync_reg[1];

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic [7:0] page_reg;
    logic [7:0] err_reg;
    logic [7:0] hp_reg;
    logic [7:0] spk_reg;
    logic       on_page_one;
    logic       wr_page;
    logic       wr_err;
    logic       wr_hp;
    logic       wr_spk;

    assign on_page_one = (page_reg == odp_pkg::PAGE_ONE);
    assign wr_page = REG_WR && (REG_ADDR == odp_pkg::OFS_PAGE_SELECT);
    assign wr_err  = REG_WR && on_page_one
                     && (REG_ADDR == odp_pkg::OFS_ERR_CTRL);
    assign wr_hp   = REG_WR && on_page_one
                     && (REG_ADDR == odp_pkg::OFS_HP_CTRL);
    assign wr_spk  = REG_WR && on_page_one
                     && (REG_ADDR == odp_pkg::OFS_SPK_CTRL);

    // ------------------------------------------------------------
    // short-circuit actions
    // ------------------------------------------------------------
    logic hp_action_pd;
    logic hp_clear;
    logic spk_clear;
    logic hp_powered;
    logic [7:0] hp_next;
    logic [7:0] spk_next;

    assign hp_action_pd = hp_reg[odp_pkg::HP_ACTION_BIT];
    assign hp_clear  = hp_short && hp_action_pd
                       && !err_reg[odp_pkg::ERR_HP_KEEP_BIT];
    assign spk_clear = spk_short && !err_reg[odp_pkg::ERR_SPK_KEEP_BIT];

    // protective clear wins over a same-cycle host write
    always_comb begin
        hp_next = wr_hp ? REG_WDATA : hp_reg;
        hp_next[odp_pkg::HP_STATUS_BIT] = 1'b0;
        if (hp_clear) begin
            hp_next[odp_pkg::HP_POWER_BIT] = 1'b0;
        end
        spk_next = wr_spk ? REG_WDATA : spk_reg;
        spk_next[odp_pkg::SPK_STATUS_BIT] = 1'b0;
        if (spk_clear) begin
            spk_next[odp_pkg::SPK_POWER_BIT] = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            page_reg <= odp_pkg::RST_PAGE_SELECT;
            err_reg  <= odp_pkg::RST_ERR_CTRL;
            hp_reg   <= odp_pkg::RST_HP_CTRL;
            spk_reg  <= odp_pkg::RST_SPK_CTRL;
        end else begin
            if (wr_page) begin
                page_reg <= REG_WDATA;
            end
            if (wr_err) begin
                err_reg <= REG_WDATA;
            end
            hp_reg  <= hp_next;
            spk_reg <= spk_next;
        end
    end

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [7:0] rd_mux;
    logic [7:0] hp_view;
    logic [7:0] spk_view;

    assign hp_view  = {hp_reg[7:1], hp_short};
    assign spk_view = {spk_reg[7:1], spk_short};

    always_comb begin
        rd_mux = 8'h00;
        if (REG_ADDR == odp_pkg::OFS_PAGE_SELECT) begin
            rd_mux = page_reg;
        end else if (on_page_one) begin
            case (REG_ADDR)
                odp_pkg::OFS_ERR_CTRL: rd_mux = err_reg;
                odp_pkg::OFS_HP_CTRL:  rd_mux = hp_view;
                odp_pkg::OFS_SPK_CTRL: rd_mux = spk_view;
                default:               rd_mux = 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    logic        hp_en_next;
    logic        hp_lim_next;
    logic [11:0] cm_mv_next;
    logic [1:0]  cm_code;

    assign hp_powered = hp_reg[odp_pkg::HP_POWER_BIT];
    assign hp_en_next  = hp_powered && !(hp_short && hp_action_pd);
    assign hp_lim_next = hp_powered && hp_short && !hp_action_pd;
    assign cm_code = hp_reg[odp_pkg::HP_CM_MSB:odp_pkg::HP_CM_LSB];

    always_comb begin
        case (cm_code)
            2'h0:    cm_mv_next = odp_pkg::CM_MV_CODE0;
            2'h1:    cm_mv_next = odp_pkg::CM_MV_CODE1;
            2'h2:    cm_mv_next = odp_pkg::CM_MV_CODE2;
            default: cm_mv_next = odp_pkg::CM_MV_CODE3;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            REG_RDATA        <= 8'h00;
            PAGE_SEL         <= odp_pkg::RST_PAGE_SELECT;
            HP_DRIVER_EN     <= 1'b0;
            HP_CURRENT_LIMIT <= 1'b0;
            HP_CM_SEL        <= 2'h0;
            HP_CM_MV         <= odp_pkg::CM_MV_CODE0;
            SPK_DRIVER_EN    <= 1'b0;
        end else begin
            if (REG_RD) begin
                REG_RDATA <= rd_mux;
            end
            PAGE_SEL         <= page_reg;
            HP_DRIVER_EN     <= hp_en_next;
            HP_CURRENT_LIMIT <= hp_lim_next;
            HP_CM_SEL        <= cm_code;
            HP_CM_MV         <= cm_mv_next;
            SPK_DRIVER_EN    <= spk_reg[odp_pkg::SPK_POWER_BIT];
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // input rises, then two edges pass before the synced copy follows
    sequence spk_edge_s;
        $rose(SPK_SHORT_IN);
    endsequence

    sequence spk_seen_s;
        !spk_short ##1 spk_short;
    endsequence

    sequence hp_edge_s;
        $rose(HP_SHORT_IN);
    endsequence

    sequence hp_seen_s;
        !hp_short ##1 hp_short;
    endsequence

    chk_page_write: assert property (
        wr_page |=> page_reg == $past(REG_WDATA)
        ##1 PAGE_SEL == $past(page_reg))
        else $error("page select not stored");

    chk_page_read: assert property (
        REG_RD && REG_ADDR == odp_pkg::OFS_PAGE_SELECT
        |=> REG_RDATA == $past(page_reg))
        else $error("page select readback wrong");

    chk_rsvd_quiet: assert property (
        REG_RD && on_page_one && REG_ADDR >= odp_pkg::OFS_RSVD_FIRST
        && REG_ADDR <= odp_pkg::OFS_RSVD_LAST |=> REG_RDATA == 8'h00)
        else $error("reserved offset read nonzero");

    chk_err_write: assert property (
        wr_err |=> err_reg == $past(REG_WDATA))
        else $error("error control not stored");

    chk_spk_clear: assert property (
        spk_short && !err_reg[odp_pkg::ERR_SPK_KEEP_BIT]
        |=> !spk_reg[odp_pkg::SPK_POWER_BIT] ##1 !SPK_DRIVER_EN)
        else $error("speaker power not cleared on short");

    chk_spk_keep: assert property (
        spk_short && err_reg[odp_pkg::ERR_SPK_KEEP_BIT] && !wr_spk
        |=> spk_reg[odp_pkg::SPK_POWER_BIT]
            == $past(spk_reg[odp_pkg::SPK_POWER_BIT]))
        else $error("speaker power changed while kept");

    chk_spk_write: assert property (
        wr_spk && !spk_short
        |=> spk_reg[odp_pkg::SPK_POWER_BIT]
            == $past(REG_WDATA[odp_pkg::SPK_POWER_BIT]))
        else $error("speaker power bit not stored");

    chk_hp_clear: assert property (
        hp_short && hp_reg[odp_pkg::HP_ACTION_BIT]
        && !err_reg[odp_pkg::ERR_HP_KEEP_BIT]
        |=> !hp_reg[odp_pkg::HP_POWER_BIT])
        else $error("headphone power not cleared on short");

    chk_hp_pd: assert property (
        hp_short && hp_reg[odp_pkg::HP_ACTION_BIT] |=> !HP_DRIVER_EN)
        else $error("headphone driver not powered down");

    chk_hp_limit: assert property (
        hp_reg[odp_pkg::HP_POWER_BIT] && hp_short
        && !hp_reg[odp_pkg::HP_ACTION_BIT]
        |=> HP_CURRENT_LIMIT && HP_DRIVER_EN)
        else $error("headphone current limit missing");

    chk_lim_idle: assert property (
        !hp_short |=> !HP_CURRENT_LIMIT)
        else $error("current limit without short");

    chk_hp_off: assert property (
        !hp_reg[odp_pkg::HP_POWER_BIT]
        |=> !HP_DRIVER_EN && !HP_CURRENT_LIMIT)
        else $error("headphone driver on while unpowered");

    chk_hp_on: assert property (
        hp_reg[odp_pkg::HP_POWER_BIT] && !hp_short
        |=> HP_DRIVER_EN)
        else $error("headphone driver off while powered");

    chk_cm_code_zero: assert property (
        cm_code == 2'h0
        |=> HP_CM_SEL == 2'h0 && HP_CM_MV == odp_pkg::CM_MV_CODE0)
        else $error("common-mode code zero decode wrong");

    chk_cm_code_one: assert property (
        cm_code == 2'h1
        |=> HP_CM_SEL == 2'h1 && HP_CM_MV == odp_pkg::CM_MV_CODE1)
        else $error("common-mode code one decode wrong");

    chk_cm_decode: assert property (
        cm_code == 2'h2
        |=> HP_CM_SEL == 2'h2 && HP_CM_MV == odp_pkg::CM_MV_CODE2)
        else $error("common-mode decode wrong");

    chk_cm_code_three: assert property (
        cm_code == 2'h3
        |=> HP_CM_SEL == 2'h3 && HP_CM_MV == odp_pkg::CM_MV_CODE3)
        else $error("common-mode code three decode wrong");

    chk_status_read: assert property (
        REG_RD && on_page_one && REG_ADDR == odp_pkg::OFS_HP_CTRL
        |=> REG_RDATA[0] == $past(hp_short))
        else $error("headphone status readback wrong");

    chk_spk_status: assert property (
        REG_RD && on_page_one && REG_ADDR == odp_pkg::OFS_SPK_CTRL
        |=> REG_RDATA[odp_pkg::SPK_STATUS_BIT] == $past(spk_short))
        else $error("speaker status readback wrong");

    chk_sync_delay: assert property (
        spk_edge_s |=> spk_seen_s)
        else $error("speaker short not seen after two flops");

    chk_hp_sync: assert property (
        hp_edge_s |=> hp_seen_s)
        else $error("headphone short not seen after two flops");
endmodule : odp_regs

// ==== tb/odp_host.sv ====
`timescale 1ns/1ps
module odp_host (
    input  wire logic       CLK_SYS,
    input  wire logic [7:0] REG_RDATA,
    output logic            REG_WR,
    output logic            REG_RD,
    output logic      [7:0] REG_ADDR,
    output logic      [7:0] REG_WDATA
);
    initial begin
        REG_WR    = 1'b0;
        REG_RD    = 1'b0;
        REG_ADDR  = 8'h00;
        REG_WDATA = 8'h00;
    end

    // released lines show the inverse, never a stale value
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge CLK_SYS);
        #1;
        REG_WR    = 1'b1;
        REG_ADDR  = addr;
        REG_WDATA = data;
        @(posedge CLK_SYS);
        #1;
        REG_WR    = 1'b0;
        REG_ADDR  = ~addr;
        REG_WDATA = ~data;
    endtask : wr

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(posedge CLK_SYS);
        #1;
        REG_RD   = 1'b1;
        REG_ADDR = addr;
        @(posedge CLK_SYS);
        #1;
        REG_RD   = 1'b0;
        REG_ADDR = ~addr;
        @(posedge CLK_SYS);
        #1;
        data = REG_RDATA;
    endtask : rd
endmodule : odp_host

// ==== tb/tb_output_driver_protection_regs.sv ====
`timescale 1ns/1ps
module tb_output_driver_protection_regs;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        hp_sh   = 1'b0;
    logic        spk_sh  = 1'b0;
    logic        wr, rd;
    logic [7:0]  addr, wdata, rdata, page;
    logic        hp_en, hp_lim, spk_en;
    logic [1:0]  cm_sel;
    logic [11:0] cm_mv;
    int          err_total   = 0;
    int          checks_done = 0;
    logic [11:0] cm_tab [4];

    always #25 clk_sys = ~clk_sys;

    odp_regs i_dut (.CLK_SYS(clk_sys), .RST(rst), .REG_WR(wr), .REG_RD(rd),
        .REG_ADDR(addr), .REG_WDATA(wdata), .HP_SHORT_IN(hp_sh),
        .SPK_SHORT_IN(spk_sh), .REG_RDATA(rdata), .PAGE_SEL(page),
        .HP_DRIVER_EN(hp_en), .HP_CURRENT_LIMIT(hp_lim),
        .HP_CM_SEL(cm_sel), .HP_CM_MV(cm_mv), .SPK_DRIVER_EN(spk_en));

    odp_host i_host (.CLK_SYS(clk_sys), .REG_RDATA(rdata), .REG_WR(wr),
        .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata));

    // ------------------------------------------------------------
    // checking helpers
    // ------------------------------------------------------------
    task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic rdchk(logic [7:0] a, logic [7:0] exp);
        logic [7:0] d;
        i_host.rd(a, d);
        chk($sformatf("reg %h", a), {4'h0, exp}, {4'h0, d});
    endtask : rdchk

    task automatic cyc(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : cyc

    task automatic end_of_test;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #200000;
        err_total++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        cm_tab = '{odp_pkg::CM_MV_CODE0, odp_pkg::CM_MV_CODE1,
                   odp_pkg::CM_MV_CODE2, odp_pkg::CM_MV_CODE3};
        cyc(2);
        rst = 1'b0;
        chk("hp_en", 12'h0000, {11'h000, hp_en});
        chk("hp_lim", 12'h0000, {11'h000, hp_lim});
        chk("spk_en", 12'h0000, {11'h000, spk_en});
        chk("cm_mv", 12'h0546, cm_mv);
        rdchk(8'h00, 8'h00);
        i_host.wr(8'h00, 8'h01);
        cyc(1);
        chk("page", 12'h0001, {4'h0, page});
        rdchk(8'h00, 8'h01);
        rdchk(8'h10, 8'h00);
        rdchk(8'h1E, 8'h00);
        rdchk(8'h1F, 8'h04);
        rdchk(8'h20, 8'h06);
        // common-mode codes, reserved bits as required
        for (int c = 0; c < 4; c++) begin
            i_host.wr(8'h1F, 8'h84 | 8'(c << 3));
            cyc(1);
            chk("cm_sel", 12'(c), {10'h000, cm_sel});
            chk("cm_mv", cm_tab[c], cm_mv);
            chk("hp_en", 12'h0001, {11'h000, hp_en});
        end
        // headphone short, current limit
        i_host.wr(8'h1F, 8'h84);
        hp_sh = 1'b1;
        cyc(5);
        chk("hp_lim", 12'h0001, {11'h000, hp_lim});
        chk("hp_en", 12'h0001, {11'h000, hp_en});
        rdchk(8'h1F, 8'h85);
        hp_sh = 1'b0;
        cyc(5);
        chk("hp_lim", 12'h0000, {11'h000, hp_lim});
        rdchk(8'h1F, 8'h84);
        // short action power-down, keep clear then set
        for (int k = 0; k < 2; k++) begin
            i_host.wr(8'h1E, 8'(k));
            i_host.wr(8'h1F, 8'h86);
            hp_sh = 1'b1;
            cyc(5);
            chk("hp_en", 12'h0000, {11'h000, hp_en});
            chk("hp_lim", 12'h0000, {11'h000, hp_lim});
            rdchk(8'h1F, k ? 8'h87 : 8'h07);
            hp_sh = 1'b0;
            cyc(5);
            chk("hp_en", 12'(k), {11'h000, hp_en});
        end
        // speaker short, clear then keep
        for (int k = 0; k < 2; k++) begin
            i_host.wr(8'h1E, 8'(k << 1));
            i_host.wr(8'h20, 8'h86);
            cyc(1);
            chk("spk_en", 12'h0001, {11'h000, spk_en});
            spk_sh = 1'b1;
            cyc(5);
            rdchk(8'h20, k ? 8'h87 : 8'h07);
            chk("spk_en", 12'(k), {11'h000, spk_en});
            spk_sh = 1'b0;
            cyc(5);
            rdchk(8'h20, k ? 8'h86 : 8'h06);
        end
        // page zero hides the page-one control registers
        i_host.wr(8'h00, 8'h00);
        cyc(1);
        chk("page", 12'h0000, {4'h0, page});
        rdchk(8'h1F, 8'h00);
        end_of_test();
    end
endmodule : tb_output_driver_protection_regs
